// File: sotf_ctrl.v
// start-up timeout timer, limit and response command registers, fault response
`timescale 1ns/100ps
`include "sotf_regs.vh"
module sotf_ctrl #(
    parameter TICK_CYCLES = `SOTF_MS_NS / `SOTF_CLK_NS,
    parameter TICK_W = 17
) (
    input wire mclk,
    input wire rst_n,
    input wire cmd_valid,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire store_all,
    input wire restore_all,
    input wire clear_faults,
    input wire off_cmd,
    input wire softstart_begin,
    input wire ramp_end,
    input wire [6:0] rise_time_ms,
    input wire vout_above_uv,
    input wire loop_slave,
    input wire startup_alert_mask,
    output reg rsp_valid,
    output reg rsp_nack,
    output reg [15:0] rsp_rdata,
    output reg startup_timeout_flag,
    output reg output_voltage_fault_flag,
    output reg other_fault_flag,
    output reg cml_fault_flag,
    output reg invalid_data_flag,
    output reg invalid_command_fault,
    output reg alert_n,
    output reg power_enable,
    output reg retry_request
);
    // timer states
    localparam ST_IDLE = 3'd0;
    localparam ST_RAMP = 3'd1;
    localparam ST_POST = 3'd2;
    localparam ST_OFF = 3'd3;
    localparam ST_WAIT = 3'd4;
    localparam [11:0] POST_MS = `SOTF_POST_RAMP_MS;
    localparam [11:0] RETRY_RISES = `SOTF_RETRY_RISES; // rise times waited before a retry

    reg [6:0] limit_mant; // programmable mantissa of the limit
    reg response_select; // shutdown when set
    reg retry_setting; // one bit stands for all three retry bits
    reg nv_select; // nonvolatile copy of the select bit
    reg nv_retry; // nonvolatile copy of retry bit 5
    reg [2:0] state; // timer state
    reg [11:0] ms_cnt; // elapsed milliseconds
    reg [TICK_W-1:0] div_cnt; // clock divider for the ms tick
    reg ramp_done; // rise phase has ended
    reg slave_s1, slave_s2; // loop slave strap synchroniser
    reg uv_s1, uv_s2; // undervoltage comparator synchroniser

    // bucket table: mantissa mapped to the effective limit of its bucket, rounded up or down
    function [6:0] sotf_bucket;
        input [6:0] m;
        begin
            if (m <= 7'd6) sotf_bucket = m;
            else if (m <= 7'd9) sotf_bucket = 7'd7;
            else if (m <= 7'd12) sotf_bucket = 7'd10;
            else if (m <= 7'd17) sotf_bucket = 7'd14;
            else if (m <= 7'd22) sotf_bucket = 7'd19;
            else if (m <= 7'd32) sotf_bucket = 7'd27;
            else if (m <= 7'd44) sotf_bucket = 7'd37;
            else if (m <= 7'd62) sotf_bucket = 7'd52;
            else if (m <= 7'd86) sotf_bucket = 7'd72;
            else sotf_bucket = 7'd100;
        end
    endfunction

    wire [6:0] limit_eff = sotf_bucket(limit_mant);
    wire limit_on = (limit_eff != 7'd0);
    wire limit_hit = limit_on && (ms_cnt >= {5'h00, limit_eff});
    wire tick = (div_cnt == TICK_CYCLES - 1);
    wire [6:0] rise_eff = (rise_time_ms == 7'd0) ? 7'd1 : rise_time_ms;
    wire [11:0] wait_ms = {5'h00, rise_eff} * RETRY_RISES;
    wire [11:0] wait_target = wait_ms;
    wire hit_reg = (cmd_code == `SOTF_CMD_LIMIT) || (cmd_code == `SOTF_CMD_RESP);
    wire locked = cmd_valid && hit_reg && slave_s2;
    wire wr_ok = cmd_valid && cmd_write && hit_reg && !slave_s2;
    wire retry_bad = (cmd_wdata[5:3] != 3'b000) && (cmd_wdata[5:3] != 3'b111);
    wire resp_reject = wr_ok && (cmd_code == `SOTF_CMD_RESP) && retry_bad;

    // fault detection and next state
    reg fault_evt;
    reg [2:0] next_state;
    reg [11:0] next_cnt;
    reg next_ramp_done;
    reg next_power;
    reg next_retry;
    always @* begin
        fault_evt = 1'b0;
        next_state = state;
        next_cnt = ms_cnt;
        next_ramp_done = ramp_done;
        next_power = power_enable;
        next_retry = 1'b0;
        if (tick && ms_cnt != 12'hfff) begin
            next_cnt = ms_cnt + 12'h001;
        end
        case (state)
            ST_IDLE: begin
                // wait for a soft start
                if (softstart_begin) begin
                    next_state = ST_RAMP;
                    next_cnt = 12'h000;
                    next_ramp_done = 1'b0;
                end
            end
            ST_RAMP: begin
                // counting during the rise
                if (uv_s2) begin
                    next_state = ST_IDLE;
                end else if (ramp_end && limit_hit) begin
                    next_state = ST_POST;
                    next_cnt = 12'h000;
                end else if (ramp_end) begin
                    next_ramp_done = 1'b1;
                end else if (ramp_done && limit_hit) begin
                    fault_evt = 1'b1;
                end
            end
            ST_POST: begin
                // grace period after the limit and the rise expire
                if (uv_s2) begin
                    next_state = ST_IDLE;
                end else if (tick && ms_cnt == POST_MS - 12'h001) begin
                    fault_evt = 1'b1;
                end
            end
            ST_OFF: begin
                // latched off until faults are cleared or an off command arrives
                if (clear_faults) begin
                    next_state = ST_IDLE;
                    next_power = 1'b1;
                end
            end
            ST_WAIT: begin
                // seven rise times before the retry
                if (tick && next_cnt >= wait_target) begin
                    next_state = ST_IDLE;
                    next_power = 1'b1;
                    next_retry = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (fault_evt) begin
            next_cnt = 12'h000;
            if (response_select && retry_setting) begin
                next_state = ST_WAIT;
                next_power = 1'b0;
            end else if (response_select) begin
                next_state = ST_OFF;
                next_power = 1'b0;
            end else begin
                next_state = ST_IDLE;
            end
        end
        if (off_cmd) begin
            next_state = ST_IDLE;
            next_power = 1'b1;
            next_retry = 1'b0;
        end
    end

    // input synchronisers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slave_s1 <= 1'b0;
            slave_s2 <= 1'b0;
            uv_s1 <= 1'b0;
            uv_s2 <= 1'b0;
        end else begin
            slave_s1 <= loop_slave;
            slave_s2 <= slave_s1;
            uv_s1 <= vout_above_uv;
            uv_s2 <= uv_s1;
        end
    end

    // millisecond divider, restarted at ramp start
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= {TICK_W{1'b0}};
        end else if ((state == ST_IDLE && softstart_begin) || tick) begin
            div_cnt <= {TICK_W{1'b0}};
        end else begin
            div_cnt <= div_cnt + {{(TICK_W-1){1'b0}}, 1'b1};
        end
    end

    // timer state registers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            ms_cnt <= 12'h000;
            ramp_done <= 1'b0;
            power_enable <= 1'b1;
            retry_request <= 1'b0;
        end else begin
            state <= next_state;
            ms_cnt <= next_cnt;
            ramp_done <= next_ramp_done;
            power_enable <= next_power;
            retry_request <= next_retry;
        end
    end

    // command registers and nonvolatile copies
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            limit_mant <= `SOTF_LIMIT_RST;
            response_select <= `SOTF_RESP_SEL_RST;
            retry_setting <= `SOTF_RESP_RETRY_RST;
            nv_select <= `SOTF_RESP_SEL_RST;
            nv_retry <= `SOTF_RESP_RETRY_RST;
        end else begin
            if (wr_ok && cmd_code == `SOTF_CMD_LIMIT) begin
                limit_mant <= cmd_wdata[6:0];
            end else if (restore_all) begin
                limit_mant <= `SOTF_LIMIT_RST;
            end
            if (wr_ok && cmd_code == `SOTF_CMD_RESP) begin
                response_select <= cmd_wdata[`SOTF_BIT_SEL];
                if (!retry_bad) begin
                    retry_setting <= cmd_wdata[`SOTF_BIT_RETRY];
                end
            end else if (restore_all) begin
                response_select <= nv_select;
                retry_setting <= nv_retry;
            end
            if (store_all) begin
                nv_select <= response_select;
                nv_retry <= retry_setting;
            end
        end
    end

    // command answers, one cycle after the request
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_nack <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= cmd_valid;
            rsp_nack <= cmd_valid && (!hit_reg || slave_s2);
            if (cmd_valid && !cmd_write && !slave_s2 && cmd_code == `SOTF_CMD_LIMIT) begin
                rsp_rdata <= {9'h000, limit_mant};
            end else if (cmd_valid && !cmd_write && !slave_s2 && cmd_code == `SOTF_CMD_RESP) begin
                rsp_rdata <= {8'h00, response_select, 1'b0, {6{retry_setting}}};
            end else begin
                rsp_rdata <= 16'h0000;
            end
        end
    end

    // sticky status flags, a set beats a clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            startup_timeout_flag <= 1'b0;
            output_voltage_fault_flag <= 1'b0;
            other_fault_flag <= 1'b0;
            cml_fault_flag <= 1'b0;
            invalid_data_flag <= 1'b0;
            invalid_command_fault <= 1'b0;
        end else begin
            startup_timeout_flag <= (startup_timeout_flag && !clear_faults) || fault_evt;
            output_voltage_fault_flag <= (output_voltage_fault_flag && !clear_faults) || fault_evt;
            other_fault_flag <= (other_fault_flag && !clear_faults) || fault_evt;
            cml_fault_flag <= (cml_fault_flag && !clear_faults) || resp_reject;
            invalid_data_flag <= (invalid_data_flag && !clear_faults) || resp_reject;
            invalid_command_fault <= (invalid_command_fault && !clear_faults) || locked;
        end
    end

    // alert line, low while any unmasked fault is pending
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= !((fault_evt && !startup_alert_mask) || resp_reject || locked ||
                (startup_timeout_flag && !startup_alert_mask && !clear_faults) ||
                ((cml_fault_flag || invalid_command_fault) && !clear_faults));
        end
    end
endmodule

// File: sotf_regs.vh
// constants for the start-up timeout supervisor
`ifndef SOTF_REGS_VH
`define SOTF_REGS_VH
`define SOTF_CMD_LIMIT 8'h62
`define SOTF_CMD_RESP 8'h63
`define SOTF_LIMIT_RST 7'h00
`define SOTF_RESP_SEL_RST 1'b1
`define SOTF_RESP_RETRY_RST 1'b1
`define SOTF_BIT_SEL 7
`define SOTF_BIT_RETRY 5
`define SOTF_CLK_NS 10
`define SOTF_MS_NS 1000000
`define SOTF_POST_RAMP_MS 4000
`define SOTF_RETRY_RISES 7
`endif

// File: sotf_chk.sv
// assertions on the start-up timeout supervisor ports
`timescale 1ns/100ps
module sotf_chk (
    input wire mclk,
    input wire rst_n,
    input wire cmd_valid,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire rsp_valid,
    input wire rsp_nack,
    input wire [15:0] rsp_rdata,
    input wire startup_timeout_flag,
    input wire output_voltage_fault_flag,
    input wire other_fault_flag,
    input wire cml_fault_flag,
    input wire invalid_data_flag,
    input wire startup_alert_mask,
    input wire alert_n,
    input wire power_enable,
    input wire retry_request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // reads of the limit and response codes, and the fault event
    sequence rd_lim; cmd_valid && !cmd_write && cmd_code == 8'h62; endsequence
    sequence rd_rsp; cmd_valid && !cmd_write && cmd_code == 8'h63; endsequence
    sequence hit; $rose(startup_timeout_flag); endsequence
    AST_ANSWER: assert property (cmd_valid |=> rsp_valid) else $error("no answer");
    AST_QUIET: assert property (!cmd_valid |=> !rsp_valid) else $error("stray answer");
    AST_LIM_RD: assert property (rd_lim |=> rsp_nack || rsp_rdata[15:7] == 9'h0) else $error("limit top");
    AST_RSP_RD: assert property (rd_rsp |=> rsp_nack || rsp_rdata[6:0] == {1'b0, {6{rsp_rdata[5]}}})
        else $error("response layout");
    AST_FLAGS: assert property (hit |-> other_fault_flag && output_voltage_fault_flag) else $error("status");
    AST_ALERT: assert property ($rose(startup_timeout_flag) && !startup_alert_mask |-> ##[0:1] !alert_n)
        else $error("alert");
    AST_CML: assert property ($rose(cml_fault_flag) |-> invalid_data_flag) else $error("cml");
    AST_RETRY: assert property (retry_request |=> power_enable && !retry_request) else $error("retry");
    AST_OFF: assert property ($fell(power_enable) |-> ##[0:1] startup_timeout_flag) else $error("off");
endmodule

// File: sotf_host.sv
// host model issuing limit and response commands
`timescale 1ns/100ps
module sotf_host (
    input wire mclk,
    input wire rsp_valid,
    input wire rsp_nack,
    input wire [15:0] rsp_rdata,
    output reg cmd_valid = 1'b0,
    output reg cmd_write = 1'b0,
    output reg [7:0] cmd_code = 8'h00,
    output reg [15:0] cmd_wdata = 16'h0000
);
    // one command held for one cycle, answer taken one cycle after
    task xfer(input logic wr, input logic [7:0] code, input logic [15:0] d, output logic nk, output logic [15:0] rd);
        begin
            @(negedge mclk);
            cmd_valid = 1'b1;
            cmd_write = wr;
            cmd_code = code;
            cmd_wdata = d;
            @(negedge mclk);
            cmd_valid = 1'b0;
            cmd_wdata = ~d; // released data does not keep its value
            nk = rsp_nack;
            rd = rsp_valid ? rsp_rdata : 16'hdead;
        end
    endtask
endmodule

// File: sotf_ctrl_tb.sv
// self-checking bench for the start-up timeout supervisor
`timescale 1ns/100ps
module sotf_ctrl_tb;
    localparam TICK = 10; // cycles per millisecond here
    reg mclk = 1'b0, rst_n = 1'b0, store_all = 1'b0, restore_all = 1'b0, clear_faults = 1'b0, off_cmd = 1'b0;
    reg softstart_begin = 1'b0, ramp_end = 1'b0, vout_above_uv = 1'b0, loop_slave = 1'b0;
    reg startup_alert_mask = 1'b0;
    reg [6:0] rise_time_ms = 7'h02;
    wire cmd_valid, cmd_write, rsp_valid, rsp_nack, startup_timeout_flag, output_voltage_fault_flag;
    wire other_fault_flag, cml_fault_flag, invalid_data_flag, invalid_command_fault, alert_n;
    wire power_enable, retry_request;
    wire [7:0] cmd_code;
    wire [15:0] cmd_wdata, rsp_rdata;
    integer err_total = 0, n_tests = 0, n;
    logic nk;
    logic [15:0] rd;
    always #5 mclk = ~mclk;
    sotf_ctrl #(.TICK_CYCLES(TICK)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .store_all(store_all), .restore_all(restore_all), .clear_faults(clear_faults),
        .off_cmd(off_cmd), .softstart_begin(softstart_begin), .ramp_end(ramp_end), .rise_time_ms(rise_time_ms),
        .vout_above_uv(vout_above_uv), .loop_slave(loop_slave), .startup_alert_mask(startup_alert_mask),
        .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata),
        .startup_timeout_flag(startup_timeout_flag), .output_voltage_fault_flag(output_voltage_fault_flag),
        .other_fault_flag(other_fault_flag), .cml_fault_flag(cml_fault_flag),
        .invalid_data_flag(invalid_data_flag), .invalid_command_fault(invalid_command_fault),
        .alert_n(alert_n), .power_enable(power_enable), .retry_request(retry_request)
    );
    sotf_host host_u (
        .mclk(mclk), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata)
    );
    task end_of_test;
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task rdx(input logic [7:0] code, input logic [15:0] exp);
        host_u.xfer(1'b0, code, 16'h0000, nk, rd);
        chk("read data", exp, rd);
    endtask
    task wrx(input logic [7:0] code, input logic [15:0] d, input logic exp_nk);
        host_u.xfer(1'b1, code, d, nk, rd);
        chk("nack", {15'h0, exp_nk}, {15'h0, nk});
    endtask
    // k: 0 store, 1 restore, 2 clear, 3 off
    task pulse(input integer k);
        @(negedge mclk);
        {off_cmd, clear_faults, restore_all, store_all} = 4'h1 << k;
        @(negedge mclk);
        {off_cmd, clear_faults, restore_all, store_all} = 4'h0;
    endtask
    // idle, then ramp start with the ramp end right behind it
    task launch;
        pulse(3);
        @(negedge mclk);
        softstart_begin = 1'b1;
        @(negedge mclk);
        softstart_begin = 1'b0;
        ramp_end = 1'b1;
        @(negedge mclk);
        ramp_end = 1'b0;
    endtask
    // bounded wait for the fault flag (sel 0) or a retry pulse (sel 1)
    task wait_hi(input integer sel, input integer lim);
        n = 0;
        while ((sel ? retry_request : startup_timeout_flag) !== 1'b1) begin
            @(negedge mclk);
            n = n + 1;
            if (n > lim) begin
                chk("wait bound", 16'h0, 16'h1);
                end_of_test;
            end
        end
    endtask
    task t_regs;
        rdx(8'h62, 16'h0000);
        rdx(8'h63, 16'h00bf);
        wrx(8'h62, 16'hffff, 1'b0);
        rdx(8'h62, 16'h007f);
        wrx(8'h63, 16'h0000, 1'b0);
        wrx(8'h63, 16'h00a8, 1'b0);
        chk("bad retry", 16'h3, {cml_fault_flag, invalid_data_flag});
        rdx(8'h63, 16'h0080);
        wrx(8'h64, 16'h0000, 1'b1);
        pulse(0);
        wrx(8'h63, 16'h00bf, 1'b0);
        pulse(1);
        rdx(8'h63, 16'h0080);
        rdx(8'h62, 16'h0000);
        pulse(2);
    endtask
    task t_bucket;
        int mant[4] = '{1, 8, 10, 87};
        int eff[4] = '{1, 7, 10, 100};
        wrx(8'h63, 16'h0000, 1'b0);
        for (int i = 0; i < 4; i = i + 1) begin
            wrx(8'h62, mant[i][15:0], 1'b0);
            launch;
            wait_hi(0, eff[i] * TICK + 20);
            chk("limit ms", eff[i][15:0], 16'((n + 5) / TICK));
            @(negedge mclk);
            chk("fault outs", 16'h000d, {other_fault_flag, output_voltage_fault_flag, alert_n, power_enable});
            pulse(2);
        end
    endtask
    task t_zero;
        wrx(8'h62, 16'h0000, 1'b0);
        launch;
        repeat (150) @(negedge mclk);
        chk("zero limit", 16'h0, {15'h0, startup_timeout_flag});
        // leave the unbounded ramp first, or the new limit faults it at once
        pulse(3);
        wrx(8'h62, 16'h0003, 1'b0);
        launch;
        vout_above_uv = 1'b1;
        repeat (60) @(negedge mclk);
        chk("vout up", 16'h0, {15'h0, startup_timeout_flag});
        vout_above_uv = 1'b0;
    endtask
    task t_retry;
        wrx(8'h63, 16'h00bf, 1'b0);
        wrx(8'h62, 16'h0001, 1'b0);
        launch;
        wait_hi(0, 40);
        @(negedge mclk);
        chk("shut", 16'h0, {15'h0, power_enable});
        wait_hi(1, 200);
        chk("retry ms", 16'd14, 16'((n + 5) / TICK));
        pulse(2);
        wrx(8'h63, 16'h0080, 1'b0);
        launch;
        wait_hi(0, 40);
        repeat (200) @(negedge mclk);
        chk("latched", 16'h0, {15'h0, power_enable});
        pulse(2);
        @(negedge mclk);
        chk("released", 16'h1, {15'h0, power_enable});
    endtask
    task t_slave;
        loop_slave = 1'b1;
        repeat (3) @(negedge mclk);
        wrx(8'h62, 16'h0005, 1'b1);
        @(negedge mclk);
        chk("slave", 16'h2, {invalid_command_fault, alert_n});
        loop_slave = 1'b0;
        repeat (3) @(negedge mclk);
        rdx(8'h62, 16'h0001);
    endtask
    // limit shorter than the rise: fault only after the grace time; alert masked, then unmasked
    task t_post;
        pulse(2);
        startup_alert_mask = 1'b1;
        wrx(8'h62, 16'h0001, 1'b0);
        pulse(3);
        @(negedge mclk);
        softstart_begin = 1'b1;
        @(negedge mclk);
        softstart_begin = 1'b0;
        repeat (3 * TICK) @(negedge mclk);
        ramp_end = 1'b1;
        @(negedge mclk);
        ramp_end = 1'b0;
        wait_hi(0, 4000 * TICK + 20);
        chk("post ms", 16'd4000, 16'((n + 5) / TICK));
        @(negedge mclk);
        chk("masked alert", 16'h1, {15'h0, alert_n});
        startup_alert_mask = 1'b0;
        @(negedge mclk);
        chk("unmasked alert", 16'h0, {15'h0, alert_n});
        pulse(2);
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        t_regs;
        t_bucket;
        t_zero;
        t_retry;
        t_slave;
        t_post;
        end_of_test;
    end
endmodule
bind sotf_ctrl sotf_chk chk_u (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata),
    .startup_timeout_flag(startup_timeout_flag), .output_voltage_fault_flag(output_voltage_fault_flag),
    .other_fault_flag(other_fault_flag), .cml_fault_flag(cml_fault_flag), .invalid_data_flag(invalid_data_flag),
    .startup_alert_mask(startup_alert_mask), .alert_n(alert_n), .power_enable(power_enable),
    .retry_request(retry_request)
);
